// ---- pkg/gpib_pkg.sv ----
`default_nettype none
package gpib_pkg;
  // universal commands (hex codes as transmitted)
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  // addressed commands
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_GET = 8'h08;
  // address groups
  localparam logic [2:0] GRP_LAD = 3'h1;
  localparam logic [2:0] GRP_TAD = 3'h2;
  localparam logic [2:0] GRP_SEC = 3'h3;
  localparam logic [4:0] ADDR_UNADDR = 5'h1F;
  localparam logic [3:0] PPE_TAG = 4'h6;
  localparam logic [3:0] PPD_TAG = 4'h7;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 9;
  // byte with end flag
  typedef struct packed {
    logic eoi;
    logic [7:0] data;
  } gpib_byte_type;
  // acceptor and source handshake states
  typedef enum logic [1:0] {
    GPIB_AH_IDLE = 2'b00,
    GPIB_AH_READY = 2'b01,
    GPIB_AH_TAKEN = 2'b10
  } gpib_ah_type;
  typedef enum logic [1:0] {
    GPIB_SH_IDLE = 2'b00,
    GPIB_SH_WAIT = 2'b01,
    GPIB_SH_DAV = 2'b10,
    GPIB_SH_DROP = 2'b11
  } gpib_sh_type;
endpackage
`default_nettype wire

// ---- design/gpib_fifo.sv ----
`default_nettype none
module gpib_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  // honest full and empty from pointer compare
  assign in_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  // storage
  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) mem[wp_r[AW-1:0]] <= in_data;
  end
  // pointers
  always_ff @(posedge core_clk) begin
    if (rst || flush) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (in_valid && in_ready) wp_r <= wp_r + 1'b1;
      if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
    end
  end
endmodule // gpib_fifo
`default_nettype wire

// ---- design/gpib_port.sv ----
`default_nettype none
module gpib_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // own primary address and local controls
  input wire logic [4:0] my_addr,
  input wire logic panel_local,
  input wire logic rsv,
  input wire logic [7:0] status_byte,
  // bus data lines, oe low drives
  input wire logic [7:0] dio_i,
  output logic [7:0] dio_o,
  output logic [7:0] dio_oe_n,
  // control lines
  input wire logic atn_n,
  input wire logic ifc_n,
  input wire logic ren_n,
  input wire logic eoi_i_n,
  output logic eoi_o_n,
  output logic eoi_oe_n,
  output logic srq_o_n,
  output logic srq_oe_n,
  // handshake lines
  input wire logic dav_i_n,
  output logic dav_o_n,
  output logic dav_oe_n,
  input wire logic nrfd_i_n,
  output logic nrfd_o_n,
  output logic nrfd_oe_n,
  input wire logic ndac_i_n,
  output logic ndac_o_n,
  output logic ndac_oe_n,
  // received device bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output gpib_pkg::gpib_byte_type rx_byte,
  // bytes to send as talker
  input wire logic tx_valid,
  output logic tx_ready,
  input wire gpib_pkg::gpib_byte_type tx_byte,
  // state and events
  output logic remote_r,
  output logic lockout_r,
  output logic listen_r,
  output logic talk_r,
  output logic spoll_r,
  output logic trigger_r,
  output logic dev_clear_r
);
  gpib_pkg::gpib_ah_type ah_r;
  gpib_pkg::gpib_sh_type sh_r;
  gpib_pkg::gpib_byte_type sh_byte_r;
  logic clr;
  logic cmd_take;
  logic data_take;
  logic fifo_ready;
  logic rx_fifo_in_ready;
  logic ppc_wait_r;
  logic pp_cfg_r;
  logic pp_sense_r;
  logic [2:0] pp_line_r;
  logic sh_sb_r;
  logic pp_active;
  logic [7:0] pp_word;
  logic [7:0] b;

  // interface clear forces every function except remote/lockout to default
  assign clr = rst || !ifc_n;

  // command decoders used by the serial poll, trigger and clear process
  function automatic logic is_univ(input logic [7:0] v);
    return v[6:4] == 3'h1;
  endfunction
  function automatic logic is_addr(input logic [7:0] v);
    return v[6:4] == 3'h0;
  endfunction

  assign b = {1'b0, dio_i[6:0]};
  assign pp_active = !atn_n && !eoi_i_n;
  // acceptor only takes data while listening and fifo has room
  assign fifo_ready = !atn_n || (listen_r && rx_fifo_in_ready);

  // acceptor handshake
  always_ff @(posedge core_clk) begin
    if (clr) begin
      ah_r <= gpib_pkg::GPIB_AH_IDLE;
    end else begin
      case (ah_r)
        gpib_pkg::GPIB_AH_IDLE: if (dav_i_n && fifo_ready && (!atn_n || listen_r)) begin
          ah_r <= gpib_pkg::GPIB_AH_READY;
        end
        gpib_pkg::GPIB_AH_READY: if (!dav_i_n) begin
          ah_r <= gpib_pkg::GPIB_AH_TAKEN;
        end
        gpib_pkg::GPIB_AH_TAKEN: if (dav_i_n) begin
          ah_r <= gpib_pkg::GPIB_AH_IDLE;
        end
        default: ah_r <= gpib_pkg::GPIB_AH_IDLE;
      endcase
    end
  end

  assign cmd_take = ah_r == gpib_pkg::GPIB_AH_READY && !dav_i_n && !atn_n;
  assign data_take = ah_r == gpib_pkg::GPIB_AH_READY && !dav_i_n && atn_n && listen_r;
  // acceptor drives lines while participating
  assign nrfd_o_n = 1'b0;
  assign ndac_o_n = 1'b0;
  assign nrfd_oe_n = !(ah_r != gpib_pkg::GPIB_AH_READY && (!atn_n || listen_r));
  assign ndac_oe_n = !(ah_r != gpib_pkg::GPIB_AH_TAKEN && (!atn_n || listen_r));

  // addressing: listen and talk
  always_ff @(posedge core_clk) begin
    if (clr) begin
      listen_r <= 1'b0;
      talk_r <= 1'b0;
    end else if (cmd_take) begin
      if (b[6:5] == gpib_pkg::GRP_LAD[1:0]) begin
        if (b[4:0] == gpib_pkg::ADDR_UNADDR) listen_r <= 1'b0;
        else if (b[4:0] == my_addr) begin
          listen_r <= 1'b1;
          talk_r <= 1'b0;
        end
      end else if (b[6:5] == gpib_pkg::GRP_TAD[1:0]) begin
        if (b[4:0] == my_addr) begin
          talk_r <= 1'b1;
          listen_r <= 1'b0;
        end else talk_r <= 1'b0;
      end
    end
  end

  // remote/local with lockout
  always_ff @(posedge core_clk) begin
    if (rst || ren_n) begin
      remote_r <= 1'b0;
      lockout_r <= 1'b0;
    end else if (cmd_take && b == gpib_pkg::CMD_LLO) begin
      lockout_r <= 1'b1;
    end else if (cmd_take && listen_r && b == gpib_pkg::CMD_GTL) begin
      remote_r <= 1'b0;
    end else if (cmd_take && b[6:5] == gpib_pkg::GRP_LAD[1:0] && b[4:0] == my_addr) begin
      remote_r <= 1'b1;
    end else if (panel_local && !lockout_r) begin
      remote_r <= 1'b0;
    end
  end

  // serial poll, trigger and clear events
  always_ff @(posedge core_clk) begin
    if (clr) begin
      spoll_r <= 1'b0;
      trigger_r <= 1'b0;
      dev_clear_r <= 1'b0;
    end else begin
      trigger_r <= cmd_take && listen_r && is_addr(b) && b == gpib_pkg::CMD_GET;
      dev_clear_r <= cmd_take && (b == gpib_pkg::CMD_DCL || (listen_r && b == gpib_pkg::CMD_SDC));
      if (cmd_take && is_univ(b) && b == gpib_pkg::CMD_SPE) spoll_r <= 1'b1;
      else if (cmd_take && is_univ(b) && b == gpib_pkg::CMD_SPD) spoll_r <= 1'b0;
    end
  end

  // parallel poll configuration
  always_ff @(posedge core_clk) begin
    if (clr) begin
      ppc_wait_r <= 1'b0;
      pp_cfg_r <= 1'b0;
      pp_sense_r <= 1'b0;
      pp_line_r <= 3'h0;
    end else if (cmd_take) begin
      if (b == gpib_pkg::CMD_PPU) begin
        pp_cfg_r <= 1'b0;
        ppc_wait_r <= 1'b0;
      end else if (listen_r && b == gpib_pkg::CMD_PPC) begin
        ppc_wait_r <= 1'b1;
      end else if (ppc_wait_r && b[6:5] == gpib_pkg::GRP_SEC[1:0]) begin
        ppc_wait_r <= 1'b0;
        if (b[4] == 1'b0) begin
          pp_cfg_r <= 1'b1;
          pp_sense_r <= b[3];
          pp_line_r <= b[2:0];
        end else pp_cfg_r <= 1'b0;
      end else if (b[6:5] != gpib_pkg::GRP_SEC[1:0]) ppc_wait_r <= 1'b0;
    end
  end

  // receive buffer
  gpib_fifo #(.WIDTH(gpib_pkg::BYTE_W), .DEPTH(gpib_pkg::FIFO_DEPTH)) u_rx (
    .core_clk(core_clk),
    .rst(clr),
    .flush(dev_clear_r),
    .in_valid(data_take),
    .in_ready(rx_fifo_in_ready),
    .in_data({!eoi_i_n, dio_i}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_byte)
  );

  // source handshake, serial poll sends status byte
  assign tx_ready = talk_r && atn_n && !spoll_r && sh_r == gpib_pkg::GPIB_SH_IDLE;
  always_ff @(posedge core_clk) begin
    if (clr) begin
      sh_r <= gpib_pkg::GPIB_SH_IDLE;
      sh_byte_r <= '0;
      sh_sb_r <= 1'b0;
    end else if (!atn_n && sh_r != gpib_pkg::GPIB_SH_IDLE) begin
      sh_r <= gpib_pkg::GPIB_SH_IDLE; // controller takes the bus
      sh_sb_r <= 1'b0;
    end else begin
      case (sh_r)
        gpib_pkg::GPIB_SH_IDLE: if (talk_r && atn_n) begin
          if (spoll_r && !sh_sb_r) begin
            sh_byte_r <= '{eoi: 1'b1, data: {status_byte[7], rsv, status_byte[5:0]}};
            sh_sb_r <= 1'b1;
            sh_r <= gpib_pkg::GPIB_SH_WAIT;
          end else if (!spoll_r && tx_valid) begin
            sh_byte_r <= tx_byte;
            sh_r <= gpib_pkg::GPIB_SH_WAIT;
          end
        end
        gpib_pkg::GPIB_SH_WAIT: if (nrfd_i_n) sh_r <= gpib_pkg::GPIB_SH_DAV;
        gpib_pkg::GPIB_SH_DAV: if (ndac_i_n) sh_r <= gpib_pkg::GPIB_SH_DROP;
        gpib_pkg::GPIB_SH_DROP: sh_r <= gpib_pkg::GPIB_SH_IDLE;
        default: sh_r <= gpib_pkg::GPIB_SH_IDLE;
      endcase
      if (!spoll_r) sh_sb_r <= 1'b0;
    end
  end
  // DAV low only while data stable
  assign dav_o_n = 1'b0;
  assign dav_oe_n = sh_r != gpib_pkg::GPIB_SH_DAV;
  assign eoi_o_n = 1'b0;
  assign eoi_oe_n = !((sh_r == gpib_pkg::GPIB_SH_WAIT || sh_r == gpib_pkg::GPIB_SH_DAV) && sh_byte_r.eoi
                     && !spoll_r);
  // service request
  assign srq_o_n = 1'b0;
  assign srq_oe_n = !(rsv && !clr);
  // parallel poll response overrides data lines
  assign pp_word = 8'h01 << pp_line_r;
  always_comb begin
    dio_o = 8'h00;
    dio_oe_n = 8'hFF;
    if (pp_active && pp_cfg_r && (rsv == pp_sense_r)) begin
      dio_oe_n = ~pp_word;
    end else if (sh_r == gpib_pkg::GPIB_SH_WAIT || sh_r == gpib_pkg::GPIB_SH_DAV) begin
      dio_o = sh_byte_r.data;
      dio_oe_n = ~sh_byte_r.data;
    end
  end
endmodule // gpib_port
`default_nettype wire

// ---- dv/gpib_checker.sv ----
`default_nettype none
module gpib_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus inputs
  input wire logic rsv,
  input wire logic ifc_n,
  input wire logic ren_n,
  input wire logic atn_n,
  input wire logic eoi_i_n,
  input wire logic dav_i_n,
  input wire logic ndac_i_n,
  // bus drives and state
  input wire logic [7:0] dio_oe_n,
  input wire logic dav_oe_n,
  input wire logic ndac_oe_n,
  input wire logic srq_oe_n,
  input wire logic listen_r,
  input wire logic talk_r,
  input wire logic remote_r,
  input wire logic trigger_r,
  input wire logic dev_clear_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // service request pulls the line within two cycles
  chk_srq_pull: assert property ($rose(rsv) |-> ##[0:2] !srq_oe_n) else $error("srq not pulled");
  chk_srq_free: assert property (!rsv [*3] |-> srq_oe_n) else $error("srq held without request");
  chk_ifc_clear: assert property (!ifc_n |=> !listen_r && !talk_r) else $error("ifc left role");
  chk_remote_ren: assert property (ren_n |=> !remote_r) else $error("remote without enable");
  chk_trig_pulse: assert property (trigger_r |=> !trigger_r) else $error("trigger not a pulse");
  chk_clear_pulse: assert property (dev_clear_r |=> !dev_clear_r) else $error("clear not a pulse");
  chk_one_role: assert property (!(listen_r && talk_r)) else $error("talk and listen");
  // under command (atn low) the acceptor lets ndac go only while a byte is offered
  chk_ndac_rel: assert property ($rose(ndac_oe_n) && !atn_n && ifc_n |-> !dav_i_n)
    else $error("ndac freed without dav");
  chk_dav_data: assert property (!dav_oe_n && !$past(dav_oe_n) |-> $stable(dio_oe_n))
    else $error("data moved under dav");
  chk_dav_drop: assert property ($rose(dav_oe_n) && atn_n && $past(atn_n) && ifc_n |-> $past(ndac_i_n))
    else $error("dav dropped early");
  chk_pp_quiet: assert property ((!atn_n && eoi_i_n) [*3] |-> dio_oe_n == 8'hFF)
    else $error("data driven under command");
  // main scenarios
  cov_trig: cover property (trigger_r);
  cov_src: cover property (!dav_oe_n);
  cov_pp: cover property (!atn_n && !eoi_i_n && dio_oe_n != 8'hFF);
endmodule // gpib_checker
bind gpib_port gpib_checker u_chk (.core_clk(core_clk), .rst(rst), .rsv(rsv), .ifc_n(ifc_n), .ren_n(ren_n),
  .atn_n(atn_n), .eoi_i_n(eoi_i_n), .dav_i_n(dav_i_n), .ndac_i_n(ndac_i_n), .dio_oe_n(dio_oe_n),
  .dav_oe_n(dav_oe_n), .ndac_oe_n(ndac_oe_n), .srq_oe_n(srq_oe_n), .listen_r(listen_r), .talk_r(talk_r),
  .remote_r(remote_r), .trigger_r(trigger_r), .dev_clear_r(dev_clear_r));
`default_nettype wire

// ---- dv/gpib_ctrl_model.sv ----
`default_nettype none
module gpib_ctrl_model (
  // clock
  input wire logic core_clk,
  // device drives
  input wire logic [7:0] dio_oe_n,
  input wire logic dav_oe_n,
  input wire logic nrfd_oe_n,
  input wire logic ndac_oe_n,
  input wire logic eoi_oe_n,
  // line levels
  output logic [7:0] dio_i,
  output logic atn_n,
  output logic eoi_i_n,
  output logic dav_i_n,
  output logic nrfd_i_n,
  output logic ndac_i_n,
  // last byte taken from a talker
  output logic [8:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dav_c = 1'b1;
  logic eoi_c = 1'b1;
  logic ndac_c = 1'b0;
  // bus idle before the first command
  initial begin
    atn_n = 1'b1;
    dio_i = 8'h00;
  end
  // open-drain lines: low when any party pulls
  assign dav_i_n = dav_c & dav_oe_n;
  assign eoi_i_n = eoi_c & eoi_oe_n;
  assign nrfd_i_n = nrfd_oe_n;
  assign ndac_i_n = ndac_c & ndac_oe_n;
  // acceptor: latch on dav, free ndac, pull again after dav ends
  always_ff @(posedge core_clk) begin
    ndac_c <= !dav_i_n;
    if (!dav_i_n && !ndac_c) got <= {!eoi_i_n, ~dio_oe_n};
  end
  // controller as source of one byte
  task automatic send(input logic [7:0] b, input logic cmd, input logic last, output logic ok);
    int n;
    n = 0;
    atn_n <= !cmd;
    dio_i <= b;
    eoi_c <= !last;
    @(posedge core_clk);
    while (!nrfd_i_n && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    dav_c <= 1'b0;
    @(posedge core_clk);
    while (!ndac_i_n && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    dav_c <= 1'b1;
    eoi_c <= 1'b1;
    dio_i <= ~b;
    @(posedge core_clk); // lets the release settle before the next byte
    ok = n < 200;
  endtask
  // parallel poll request
  task automatic poll(input logic on);
    atn_n <= !on;
    eoi_c <= !on;
    @(posedge core_clk);
  endtask
endmodule // gpib_ctrl_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ADR = 5'h05;
  localparam logic [7:0] MLA = {gpib_pkg::GRP_LAD, ADR};
  localparam logic [7:0] MTA = {gpib_pkg::GRP_TAD, ADR};
  localparam logic [7:0] UNL = {gpib_pkg::GRP_LAD, gpib_pkg::ADDR_UNADDR};
  logic core_clk = 0, rst = 1, rsv = 0, ifc_n = 1, ren_n = 1, rx_ready = 1, tx_valid = 0, panel_local = 0;
  logic tx_ready, rx_valid, atn_n, eoi_i_n, dav_i_n, nrfd_i_n, ndac_i_n, dav_oe_n, nrfd_oe_n, ndac_oe_n;
  logic eoi_oe_n, srq_o_n, srq_oe_n, remote_r, lockout_r, listen_r, talk_r, spoll_r, trigger_r, dev_clear_r;
  logic [7:0] dio_i, dio_oe_n, sb = 8'h12;
  logic [8:0] got, last_rx;
  gpib_pkg::gpib_byte_type rx_byte, tx_byte = 9'h13C;
  int errors = 0, cmp_count = 0, trig_cnt = 0, clr_cnt = 0, rx_cnt = 0;
  gpib_port u_dut (.core_clk(core_clk), .rst(rst), .my_addr(ADR), .panel_local(panel_local), .rsv(rsv),
    .status_byte(sb), .dio_i(dio_i), .dio_o(), .dio_oe_n(dio_oe_n), .atn_n(atn_n), .ifc_n(ifc_n),
    .ren_n(ren_n), .eoi_i_n(eoi_i_n), .eoi_o_n(), .eoi_oe_n(eoi_oe_n), .srq_o_n(srq_o_n), .srq_oe_n(srq_oe_n),
    .dav_i_n(dav_i_n), .dav_o_n(), .dav_oe_n(dav_oe_n), .nrfd_i_n(nrfd_i_n), .nrfd_o_n(),
    .nrfd_oe_n(nrfd_oe_n), .ndac_i_n(ndac_i_n), .ndac_o_n(), .ndac_oe_n(ndac_oe_n), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .remote_r(remote_r), .lockout_r(lockout_r), .listen_r(listen_r), .talk_r(talk_r), .spoll_r(spoll_r),
    .trigger_r(trigger_r), .dev_clear_r(dev_clear_r));
  gpib_ctrl_model u_ctrl (.core_clk(core_clk), .dio_oe_n(dio_oe_n), .dav_oe_n(dav_oe_n),
    .nrfd_oe_n(nrfd_oe_n), .ndac_oe_n(ndac_oe_n), .eoi_oe_n(eoi_oe_n), .dio_i(dio_i), .atn_n(atn_n),
    .eoi_i_n(eoi_i_n), .dav_i_n(dav_i_n), .nrfd_i_n(nrfd_i_n), .ndac_i_n(ndac_i_n), .got(got));
  // event and receive counters
  always_ff @(posedge core_clk) begin
    trig_cnt <= trig_cnt + int'(trigger_r);
    clr_cnt <= clr_cnt + int'(dev_clear_r);
    if (rx_valid && rx_ready) rx_cnt <= rx_cnt + 1;
    if (rx_valid && rx_ready) last_rx <= rx_byte;
  end
  initial forever #2 core_clk = ~core_clk;
  task automatic chk(input logic [8:0] a, input logic [8:0] e);
    cmp_count++;
    if (a !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
      errors++;
    end
  endtask
  task automatic tx(input logic [7:0] b, input logic c, input logic l);
    logic ok;
    u_ctrl.send(b, c, l, ok);
    chk({8'h00, ok}, 9'h001);
  endtask
  // wait for the model to take a byte from the device
  task automatic take(input logic [8:0] e);
    for (int i = 0; i < 60 && got !== e; i++) @(posedge core_clk);
    chk(got, e);
  endtask
  task automatic t_listen;
    ren_n <= 1'b0;
    tx(MLA, 1, 0);
    chk(listen_r, 1);
    chk(remote_r, 1);
    tx(8'hA5, 0, 1);
    repeat (4) @(posedge core_clk);
    chk(last_rx, 9'h1A5);
    tx(gpib_pkg::CMD_LLO, 1, 0);
    chk(lockout_r, 1);
    panel_local <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(remote_r, 1);
    panel_local <= 1'b0;
    tx(gpib_pkg::CMD_GET, 1, 0);
    tx(gpib_pkg::CMD_SDC, 1, 0);
    tx(gpib_pkg::CMD_GTL, 1, 0);
    chk(remote_r, 0);
    tx(UNL, 1, 0);
    tx(gpib_pkg::CMD_GET, 1, 0);
    tx(gpib_pkg::CMD_DCL, 1, 0);
    repeat (2) @(posedge core_clk);
    chk(9'(trig_cnt), 9'd1);
    chk(9'(clr_cnt), 9'd2);
    $display("listen test done");
  endtask
  task automatic t_talk;
    tx(MLA, 1, 0);
    tx(MTA, 1, 0);
    chk({listen_r, talk_r}, 2'b01);
    u_ctrl.atn_n <= 1'b1;
    tx_valid <= 1'b1;
    for (int i = 0; i < 50 && !tx_ready; i++) @(posedge core_clk);
    @(posedge core_clk);
    tx_valid <= 1'b0;
    take(9'h13C);
    rsv <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({srq_o_n, srq_oe_n}, 2'b00);
    tx(gpib_pkg::CMD_SPE, 1, 0);
    tx(MTA, 1, 0);
    u_ctrl.atn_n <= 1'b1;
    take(9'h052);
    tx(gpib_pkg::CMD_SPD, 1, 0);
    chk(spoll_r, 0);
    tx(MLA, 1, 0);
    chk(talk_r, 0);
    $display("talk test done");
  endtask
  task automatic t_ppoll;
    tx(gpib_pkg::CMD_PPC, 1, 0);
    tx({gpib_pkg::PPE_TAG, 4'hB}, 1, 0);
    u_ctrl.poll(1);
    repeat (3) @(posedge core_clk);
    chk(dio_oe_n, 8'hF7);
    u_ctrl.poll(0);
    tx(gpib_pkg::CMD_PPU, 1, 0);
    u_ctrl.poll(1);
    repeat (3) @(posedge core_clk);
    chk(dio_oe_n, 8'hFF);
    u_ctrl.poll(0);
    $display("poll test done");
  endtask
  task automatic t_fill;
    int n0;
    n0 = rx_cnt;
    rx_ready <= 1'b0;
    for (int i = 0; i < 8; i++) tx(8'(i), 0, 0);
    repeat (6) @(posedge core_clk);
    chk(nrfd_oe_n, 0);
    rx_ready <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk(9'(rx_cnt - n0), 9'd8);
    ifc_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    ifc_n <= 1'b1;
    chk(listen_r, 0);
    $display("fill test done");
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_listen();
    t_talk();
    t_ppoll();
    t_fill();
    close_out();
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
